// [core/nvm_regs.svh]
`ifndef NVM_REGS_SVH
`define NVM_REGS_SVH

// I/O register locations
`define NVM_ADDR_CONTROL      6'h1F
`define NVM_ADDR_DATA         6'h20
`define NVM_ADDR_ADDRESS_LOW  6'h21
`define NVM_ADDR_ADDRESS_HIGH 6'h22

// Control register fields
`define NVM_BIT_READ_STROBE   0
`define NVM_BIT_WRITE_STROBE  1
`define NVM_BIT_MASTER_WE     2
`define NVM_BIT_READY_IRQ_EN  3
`define NVM_BIT_MODE_LO       4
`define NVM_BIT_MODE_HI       5

// Address high register width of live bits
`define NVM_ADDR_HIGH_BITS    4

// Reset values
`define NVM_CONTROL_RESET     8'h00
`define NVM_RDATA_RESET       8'h00
`define NVM_ERASED_BYTE       8'hFF

// Timing
`define NVM_CLOCK_MHZ         100
`define NVM_ATOMIC_TIME_US    3400
`define NVM_SPLIT_TIME_US     1800
`define NVM_MASTER_WE_CYCLES  3'h4
`define NVM_READ_STALL        3'h4
`define NVM_WRITE_STALL       3'h2

`endif

// [core/nvm_pkg.sv]
package nvm_pkg;
   typedef enum logic [1:0] {
      MODE_ERASE_WRITE,
      MODE_ERASE_ONLY,
      MODE_WRITE_ONLY,
      MODE_RESERVED
   } prog_mode_t;

   typedef enum logic [1:0] {
      PROG_IDLE,
      PROG_FETCH,
      PROG_TIMING
   } prog_state_t;
endpackage : nvm_pkg

// [core/nvm_mem_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface nvm_mem_if #(
   parameter int ADDR_W = 12,
   parameter int DATA_W = 8
);
   logic              we;
   logic              re;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;

   modport ctrl  (output we, output re, output addr, output wdata, input rdata);
   modport store (input we, input re, input addr, input wdata, output rdata);
endinterface : nvm_mem_if
`default_nettype wire

// [core/nvm_byte_memory.sv]
`timescale 1ns/1ns
`default_nettype none
module nvm_byte_memory #(
   parameter int ADDR_W = 12,
   parameter int DATA_W = 8
) (
   // Clock
   input wire logic   clock_in,
   // Access port
   nvm_mem_if.store   port
);
   logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

   // Cells hold no reset: nonvolatile contents survive a system reset
   always_ff @(posedge clock_in) begin
      if (port.we) begin
         cells[port.addr] <= port.wdata;
      end
   end

   always_ff @(posedge clock_in) begin
      if (port.re) begin
         port.rdata <= cells[port.addr];
      end
   end
endmodule : nvm_byte_memory
`default_nettype wire

// [core/eeprom_access_controller.sv]
// Notes on behaviour
// - Byte-wide storage space of its own, each byte read or written alone.
// - Read strobe halts the processor for four cycles.
// - Accepted write strobe halts the processor for two cycles.
// - Writes are timed internally; busy flag shows completion.
// - Write starts only via master enable then write strobe sequence.
// - Address pair holds a 12-bit linear byte address.
// - Address register is not reset; software loads it first.
// - Write programs the data register byte at the addressed location.
// - Read loads the data register from the addressed location.
// - Control holds mode, irq enable, master enable, write and read strobes.
// - All four registers sit in the processor I/O space.
// - Master enable clears after four cycles; strobe outside window ignored.
// - Write strobe bit stays set while programming, cleared at end.
// - Mode bits pick erase+write, erase, write; locked while busy.
// - Ready interrupt asserted while idle if both enables are set.
`include "nvm_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module eeprom_access_controller
   import nvm_pkg::*;
#(
   parameter int ADDR_W        = 12,
   parameter int ATOMIC_CYCLES = `NVM_ATOMIC_TIME_US * `NVM_CLOCK_MHZ,
   parameter int SPLIT_CYCLES  = `NVM_SPLIT_TIME_US * `NVM_CLOCK_MHZ
) (
   // Clock and reset
   input  wire logic       clock_in,
   input  wire logic       rst_n_in,
   // I/O register access
   input  wire logic [5:0] io_addr_in,
   input  wire logic       io_write_in,
   input  wire logic       io_read_in,
   input  wire logic [7:0] io_wdata_in,
   output logic      [7:0] io_rdata_out,
   // Processor coupling
   input  wire logic       global_irq_enable_in,
   output logic            cpu_stall_out,
   output logic            ready_irq_out
);
   localparam int CNT_W = $clog2(ATOMIC_CYCLES + 1);

   logic [ADDR_W-1:0] nvm_address;
   logic [7:0]        nvm_data;
   prog_mode_t        prog_mode;
   logic              ready_irq_enable;
   logic              write_strobe;
   logic [2:0]        master_we_count;
   logic [2:0]        stall_count;
   prog_state_t       prog_state;
   logic [CNT_W-1:0]  prog_count;
   logic [7:0]        old_byte;
   logic              read_pending;
   logic              master_write_enable;
   logic              wr_control;
   logic              prog_start;
   logic              read_fire;
   logic              prog_done;
   prog_mode_t        written_mode;
   logic [7:0]        next_byte;

   nvm_mem_if #(.ADDR_W(ADDR_W), .DATA_W(8)) mem ();

   nvm_byte_memory #(.ADDR_W(ADDR_W), .DATA_W(8)) store_u (
      .clock_in (clock_in),
      .port     (mem.store)
   );

   assign master_write_enable = (master_we_count != 3'h0);
   assign wr_control   = io_write_in && (io_addr_in == `NVM_ADDR_CONTROL);
   assign written_mode = prog_mode_t'(io_wdata_in[`NVM_BIT_MODE_HI:`NVM_BIT_MODE_LO]);
   // Mode bits written together with the strobe take effect for that write
   assign prog_start   = wr_control && io_wdata_in[`NVM_BIT_WRITE_STROBE]
                         && master_write_enable && !write_strobe
                         && (written_mode != MODE_RESERVED);
   assign read_fire    = wr_control && io_wdata_in[`NVM_BIT_READ_STROBE]
                         && !write_strobe && !prog_start;
   assign prog_done    = (prog_state == PROG_TIMING) && (prog_count == '0);

   always_comb begin
      next_byte = io_wdata_in;
      unique case (prog_mode)
         MODE_ERASE_WRITE: next_byte = nvm_data;
         MODE_ERASE_ONLY:  next_byte = `NVM_ERASED_BYTE;
         MODE_WRITE_ONLY:  next_byte = old_byte & nvm_data;
         MODE_RESERVED:    next_byte = old_byte;
      endcase
   end

   assign mem.addr  = nvm_address;
   assign mem.re    = read_fire || prog_start;
   // Memory is written only in the last cycle of the programming time
   assign mem.we    = prog_done;
   assign mem.wdata = next_byte;

   // Address is held stable for the whole programming operation
   always_ff @(posedge clock_in) begin
      if (io_write_in && !write_strobe) begin
         if (io_addr_in == `NVM_ADDR_ADDRESS_LOW) begin
            nvm_address[7:0] <= io_wdata_in;
         end
         if (io_addr_in == `NVM_ADDR_ADDRESS_HIGH) begin
            nvm_address[ADDR_W-1:8] <= io_wdata_in[ADDR_W-9:0];
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (read_pending) begin
         nvm_data <= mem.rdata;
      end else if (io_write_in && io_addr_in == `NVM_ADDR_DATA) begin
         nvm_data <= io_wdata_in;
      end
   end

   // Memory answers one edge after the request; capture into the data register then
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         read_pending <= 1'b0;
      end else begin
         read_pending <= read_fire;
      end
   end

   // Reset always returns mode to 00, since reset also aborts any write in flight
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prog_mode        <= MODE_ERASE_WRITE;
         ready_irq_enable <= 1'b0;
      end else if (wr_control) begin
         ready_irq_enable <= io_wdata_in[`NVM_BIT_READY_IRQ_EN];
         if (!write_strobe) begin
            prog_mode <= written_mode;
         end
      end
   end

   // Window closes four edges after the enable write, so a slow handler loses it
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         master_we_count <= 3'h0;
      end else if (prog_start) begin
         master_we_count <= 3'h0;
      end else if (wr_control && io_wdata_in[`NVM_BIT_MASTER_WE]) begin
         master_we_count <= `NVM_MASTER_WE_CYCLES;
      end else if (master_we_count != 3'h0) begin
         master_we_count <= master_we_count - 3'h1;
      end
   end

   // A stalled processor issues nothing, so a running count is never reloaded
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stall_count <= 3'h0;
      end else if (read_fire) begin
         stall_count <= `NVM_READ_STALL;
      end else if (prog_start) begin
         stall_count <= `NVM_WRITE_STALL;
      end else if (stall_count != 3'h0) begin
         stall_count <= stall_count - 3'h1;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prog_state   <= PROG_IDLE;
         prog_count   <= '0;
         write_strobe <= 1'b0;
         old_byte     <= 8'h00;
      end else begin
         unique case (prog_state)
            PROG_IDLE: begin
               if (prog_start) begin
                  write_strobe <= 1'b1;
                  prog_state   <= PROG_FETCH;
               end
            end
            PROG_FETCH: begin
               old_byte   <= mem.rdata;
               prog_state <= PROG_TIMING;
               // Fetch cycle and the final zero cycle belong to the programming time
               if (prog_mode == MODE_ERASE_WRITE) begin
                  prog_count <= CNT_W'(ATOMIC_CYCLES - 2);
               end else begin
                  prog_count <= CNT_W'(SPLIT_CYCLES - 2);
               end
            end
            PROG_TIMING: begin
               if (prog_count == '0) begin
                  write_strobe <= 1'b0;
                  prog_state   <= PROG_IDLE;
               end else begin
                  prog_count <= prog_count - CNT_W'(1);
               end
            end
            default: begin
               prog_state <= PROG_IDLE;
            end
         endcase
      end
   end

   // Read data is registered, so it appears the cycle after the request
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         io_rdata_out <= `NVM_RDATA_RESET;
      end else if (io_read_in) begin
         unique case (io_addr_in)
            `NVM_ADDR_CONTROL:
               io_rdata_out <= {2'b00, prog_mode, ready_irq_enable,
                                master_write_enable, write_strobe, 1'b0};
            `NVM_ADDR_DATA:         io_rdata_out <= nvm_data;
            `NVM_ADDR_ADDRESS_LOW:  io_rdata_out <= nvm_address[7:0];
            `NVM_ADDR_ADDRESS_HIGH: io_rdata_out <= {4'h0, nvm_address[ADDR_W-1:8]};
            default:                io_rdata_out <= 8'h00;
         endcase
      end
   end

   assign cpu_stall_out = (stall_count != 3'h0);
   assign ready_irq_out = ready_irq_enable && global_irq_enable_in && !write_strobe;
endmodule : eeprom_access_controller
`default_nettype wire

// [verification/eac_sva.sv]
`timescale 1ns/1ns
`default_nettype none
`include "nvm_regs.svh"
module eac_sva (
   // Clock and reset
   input wire logic       clock_in,
   input wire logic       rst_n_in,
   // Watched ports
   input wire logic [5:0] io_addr_in,
   input wire logic       io_write_in,
   input wire logic       io_read_in,
   input wire logic [7:0] io_wdata_in,
   input wire logic [7:0] io_rdata_out,
   input wire logic       global_irq_enable_in,
   input wire logic       cpu_stall_out,
   input wire logic       ready_irq_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   wire logic ctl_wr = io_write_in && io_addr_in == `NVM_ADDR_CONTROL;
   // Ready high proves the block idle, so write_go and read_go start only from idle
   sequence master_set; ctl_wr && io_wdata_in[2] && !io_wdata_in[1]; endsequence
   sequence write_go; ctl_wr && io_wdata_in[1] && io_wdata_in[5:4] != 2'h3 && ready_irq_out; endsequence
   sequence read_go; ctl_wr && io_wdata_in[0] && !io_wdata_in[1] && ready_irq_out; endsequence
   chk_read_stall: assert property (read_go
      |=> cpu_stall_out [*4] ##1 !cpu_stall_out) else $error("read stall wrong");
   chk_write_stall: assert property (master_set ##2 write_go
      |=> cpu_stall_out [*2] ##1 !cpu_stall_out) else $error("write stall wrong");
   chk_busy_min: assert property (master_set ##2 write_go |=> !ready_irq_out [*8])
      else $error("busy too short");
   chk_late_strobe: assert property (master_set ##1 !io_write_in [*4]
      ##1 (ctl_wr && io_wdata_in[1]) |=> ready_irq_out && !cpu_stall_out)
      else $error("late strobe taken");
   chk_irq_gate: assert property (!global_irq_enable_in |-> !ready_irq_out)
      else $error("irq not gated");
   chk_ctrl_reserved: assert property (io_read_in && io_addr_in == `NVM_ADDR_CONTROL
      |=> io_rdata_out[7:6] == 2'h0 && !io_rdata_out[0]) else $error("control bits");
   chk_unmapped_zero: assert property (io_read_in && io_addr_in < `NVM_ADDR_CONTROL
      |=> io_rdata_out == 8'h00) else $error("unmapped read");
   chk_stall_cause: assert property ($rose(cpu_stall_out) |-> $past(ctl_wr))
      else $error("stall without cause");
endmodule : eac_sva
bind eeprom_access_controller eac_sva chk (
   .clock_in(clock_in), .rst_n_in(rst_n_in), .io_addr_in(io_addr_in), .io_write_in(io_write_in),
   .io_read_in(io_read_in), .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out),
   .global_irq_enable_in(global_irq_enable_in), .cpu_stall_out(cpu_stall_out),
   .ready_irq_out(ready_irq_out));
`default_nettype wire

// [verification/cpu_model.sv]
`timescale 1ns/1ns
`default_nettype none
module cpu_model (
   // Clock and stall
   input  wire logic       clock_in,
   input  wire logic       cpu_stall_in,
   // Register access
   output logic      [5:0] io_addr_out,
   output logic            io_write_out,
   output logic            io_read_out,
   output logic      [7:0] io_wdata_out,
   input  wire logic [7:0] io_rdata_in
);
   initial begin
      io_write_out = 1'b0;
      io_read_out = 1'b0;
      io_addr_out = 6'h00;
      io_wdata_out = 8'h00;
   end
   // Like the core, no access starts while the block stalls it
   task automatic access(input logic [5:0] a, input logic [7:0] d, input logic w,
                         output logic [7:0] q);
      @(negedge clock_in);
      while (cpu_stall_in !== 1'b0) @(negedge clock_in);
      io_addr_out = a;
      io_wdata_out = d;
      io_write_out = w;
      io_read_out = !w;
      @(negedge clock_in);
      q = io_rdata_in;
      io_write_out = 1'b0;
      io_read_out = 1'b0;
   endtask : access
endmodule : cpu_model
`default_nettype wire

// [verification/eeprom_access_controller_bench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "nvm_regs.svh"
module eeprom_access_controller_bench;
   localparam logic [5:0] CTL = `NVM_ADDR_CONTROL;
   localparam logic [5:0] DAT = `NVM_ADDR_DATA;
   localparam logic [5:0] LOW = `NVM_ADDR_ADDRESS_LOW;
   localparam logic [5:0] HIGH = `NVM_ADDR_ADDRESS_HIGH;
   logic clock_in, rst_n_in, irq_on;
   wire logic [5:0] addr;
   wire logic [7:0] wdata, rdata;
   wire logic wr_en, rd_en, stall, ready;
   int miscompares, total_checks, cycles;
   logic [7:0] cur;
   logic [1:0] modes [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
   logic [7:0] datas [6] = '{8'h5A, 8'h00, 8'h3C, 8'hF0, 8'h00, 8'h11};
   bit lates [6] = '{0, 0, 0, 0, 0, 1};
   eeprom_access_controller #(.ATOMIC_CYCLES(20), .SPLIT_CYCLES(10)) dut (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .io_addr_in(addr), .io_write_in(wr_en),
      .io_read_in(rd_en), .io_wdata_in(wdata), .io_rdata_out(rdata),
      .global_irq_enable_in(irq_on), .cpu_stall_out(stall), .ready_irq_out(ready));
   cpu_model cpu (.clock_in(clock_in), .cpu_stall_in(stall), .io_addr_out(addr),
      .io_write_out(wr_en), .io_read_out(rd_en), .io_wdata_out(wdata), .io_rdata_in(rdata));
   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check8
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] q;
      cpu.access(a, d, 1'b1, q);
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string what);
      logic [7:0] q;
      cpu.access(a, 8'h00, 1'b0, q);
      check8(what, exp, q);
   endtask : rd
   task automatic prog(input logic [1:0] m, input logic [7:0] d, input bit late);
      int n;
      wr(DAT, d);
      wr(CTL, 8'h0C);
      if (late) repeat (3) @(negedge clock_in);
      wr(CTL, {2'h0, m, 4'hA});
      if (!late && m != 2'h3) begin
         cur = m == 2'h0 ? d : m == 2'h1 ? 8'hFF : cur & d;
         rd(CTL, {2'h0, m, 4'hA}, "control busy");
         wr(LOW, 8'h00);
      end
      n = 0;
      while (ready !== 1'b1 && n < 100) begin
         @(negedge clock_in);
         n++;
      end
      check8("ready", 8'h01, {7'h00, ready});
      if (late || m == 2'h3) check8("strobe refused", 8'h00, n[7:0]);
      rd(LOW, 8'hBC, "address held");
      wr(CTL, 8'h09);
      rd(DAT, cur, "stored byte");
   endtask : prog
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : summarize
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   // Ceiling sits far above the few hundred cycles the sequence needs
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         summarize;
      end
   end
   initial begin
      rst_n_in = 1'b0;
      irq_on = 1'b1;
      repeat (10) @(negedge clock_in);
      rst_n_in = 1'b1;
      rd(CTL, 8'h00, "control reset");
      rd(6'h00, 8'h00, "unmapped");
      wr(HIGH, 8'hFA);
      rd(HIGH, 8'h0A, "address high");
      wr(LOW, 8'hBC);
      wr(CTL, 8'h08);
      irq_on = 1'b0;
      @(negedge clock_in);
      check8("irq gated", 8'h00, {7'h00, ready});
      irq_on = 1'b1;
      for (int i = 0; i < 6; i++) prog(modes[i], datas[i], lates[i]);
      summarize;
   end
endmodule : eeprom_access_controller_bench
`default_nettype wire
